// file: hw/mdl_margin_dac.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`default_nettype none
module mdl_margin_dac
  import mdl_pkg::*;
#(
  parameter int unsigned NUM_CH     = MDL_NUM_CH,
  parameter int unsigned SETTLE_CYC = MDL_SETTLE_CYC
) (
  input  wire logic                    mclk_i,
  input  wire logic                    reset_n_i,
  input  wire logic [MDL_ADDR_W-1:0]   addr_i,
  input  wire logic [15:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [15:0]             rdata_o,
  input  wire logic                    nv_load_i,
  input  wire logic [NUM_CH*8-1:0]     nv_lower_i,
  input  wire logic [NUM_CH*8-1:0]     nv_upper_i,
  output logic                         cfg_done_o,
  output logic      [NUM_CH*8-1:0]     dac_code_o,
  output logic      [NUM_CH*2-1:0]     dac_range_o,
  output logic      [NUM_CH-1:0]       buf_power_o,
  output logic      [NUM_CH-1:0]       buf_src_dac_o,
  output logic      [NUM_CH-1:0]       buf_drive_o
);
  ////////////////////////////////////////////////////////////////////////
  // Configuration download gate: buffer outputs stay off until limits are loaded
  logic cfg_done_r;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) cfg_done_r <= 1'b0;
    else if (nv_load_i) cfg_done_r <= 1'b1;
  end
  assign cfg_done_o = cfg_done_r;

  logic [15:0] rd_mux [NUM_CH*5];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [7:0] code_r;
      logic [7:0] lower_r;
      logic [7:0] upper_r;
      logic [1:0] range_r;
      logic       en_r;
      wire        sel_code  = (addr_i == MDL_OFS_CODE  + 6'(g));
      wire        sel_lower = (addr_i == MDL_OFS_LOWER + 6'(g));
      wire        sel_upper = (addr_i == MDL_OFS_UPPER + 6'(g));
      wire        sel_ctrl  = (addr_i == MDL_OFS_CTRL  + 6'(g));
      wire [7:0]  nv_lo     = nv_lower_i[g*8 +: 8];
      wire [7:0]  nv_hi     = nv_upper_i[g*8 +: 8];
      // Unsigned compare, purely combinational
      wire        lim_bad   = (lower_r > upper_r);
      wire        below     = (code_r < lower_r);
      wire        above     = (code_r > upper_r);
      wire [7:0]  clamped   = below ? lower_r : (above ? upper_r : code_r);
      wire        tri_st    = lim_bad || !cfg_done_r;
      logic       drv;
      // The state flop lags a limit write by one cycle, so gate the pin here
      wire        drv_out   = drv && !tri_st;

      always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
          code_r  <= MDL_CODE_RST;
          lower_r <= MDL_LOWER_RST;
          upper_r <= MDL_UPPER_RST;
          range_r <= MDL_RANGE_RST;
          en_r    <= 1'b0;
        end else begin
          if (wr_i && sel_code) code_r <= wdata_i[7:0];
          // Download overrides a same-cycle software write
          if (nv_load_i) begin
            lower_r <= nv_lo;
            upper_r <= nv_hi;
          end else begin
            if (wr_i && sel_lower) lower_r <= wdata_i[7:0];
            if (wr_i && sel_upper) upper_r <= wdata_i[7:0];
          end
          if (wr_i && sel_ctrl) begin
            range_r <= wdata_i[MDL_CTRL_RANGE_LSB +: 2];
            en_r    <= wdata_i[MDL_CTRL_EN_BIT];
          end
        end
      end

      mdl_buf_seq #(
        .SETTLE_CYC (SETTLE_CYC)
      ) u_seq (
        .mclk_i        (mclk_i),
        .reset_n_i     (reset_n_i),
        .enable_i      (en_r),
        .tristate_i    (tri_st),
        .buf_power_o   (buf_power_o[g]),
        .buf_src_dac_o (buf_src_dac_o[g]),
        .buf_drive_o   (drv)
      );
      assign buf_drive_o[g] = drv_out;

      // Analog DAC decodes unsigned code about midcode per selected range
      assign dac_code_o[g*8 +: 8]  = clamped;
      assign dac_range_o[g*2 +: 2] = range_r;

      assign rd_mux[g]            = {8'h00, code_r};
      assign rd_mux[NUM_CH + g]   = {8'h00, lower_r};
      assign rd_mux[2*NUM_CH + g] = {8'h00, upper_r};
      assign rd_mux[3*NUM_CH + g] = {13'h0000, en_r, range_r};
      assign rd_mux[4*NUM_CH + g] = {6'h00, lim_bad, drv_out, clamped};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped addresses read zero
  logic [15:0] rd_sel;
  always_comb begin
    rd_sel = 16'h0000;
    for (int i = 0; i < NUM_CH; i++) begin
      if (addr_i == MDL_OFS_CODE  + 6'(i)) rd_sel = rd_mux[i];
      if (addr_i == MDL_OFS_LOWER + 6'(i)) rd_sel = rd_mux[NUM_CH + i];
      if (addr_i == MDL_OFS_UPPER + 6'(i)) rd_sel = rd_mux[2*NUM_CH + i];
      if (addr_i == MDL_OFS_CTRL  + 6'(i)) rd_sel = rd_mux[3*NUM_CH + i];
      if (addr_i == MDL_OFS_STAT  + 6'(i)) rd_sel = rd_mux[4*NUM_CH + i];
    end
  end

  logic [15:0] rdata_r;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) rdata_r <= 16'h0000;
    else if (rd_i) rdata_r <= rd_sel;
    else rdata_r <= 16'h0000;
  end
  assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// file: hw/mdl_pkg.sv
`default_nettype none
package mdl_pkg;
  // Channel count and code width
  localparam int unsigned MDL_NUM_CH    = 6;
  localparam int unsigned MDL_CODE_W    = 8;
  localparam int unsigned MDL_ADDR_W    = 6;
  // Register offsets: channel n uses base + n
  localparam logic [5:0] MDL_OFS_CODE   = 6'h00;
  localparam logic [5:0] MDL_OFS_LOWER  = 6'h08;
  localparam logic [5:0] MDL_OFS_UPPER  = 6'h10;
  localparam logic [5:0] MDL_OFS_CTRL   = 6'h18;
  localparam logic [5:0] MDL_OFS_STAT   = 6'h20;
  // Control field layout: [1:0] range select, [2] enable
  localparam int unsigned MDL_CTRL_RANGE_LSB = 0;
  localparam int unsigned MDL_CTRL_EN_BIT    = 2;
  // Status field layout: [7:0] applied code, [8] driving, [9] tristated by limits
  localparam int unsigned MDL_STAT_DRV_BIT   = 8;
  localparam int unsigned MDL_STAT_TRI_BIT   = 9;
  // Reset values
  localparam logic [7:0] MDL_CODE_RST   = 8'h7F;
  localparam logic [7:0] MDL_LOWER_RST  = 8'hFF;
  localparam logic [7:0] MDL_UPPER_RST  = 8'h00;
  localparam logic [1:0] MDL_RANGE_RST  = 2'h0;
  localparam logic [7:0] MDL_MIDCODE    = 8'h7F;
  // Range select encodings: midcode at 0.6, 0.8, 1.0, 1.25 V
  localparam logic [1:0] MDL_RANGE_0V60 = 2'h0;
  localparam logic [1:0] MDL_RANGE_0V80 = 2'h1;
  localparam logic [1:0] MDL_RANGE_1V00 = 2'h2;
  localparam logic [1:0] MDL_RANGE_1V25 = 2'h3;
  // Buffer settle time in pin-following mode before driving
  localparam int unsigned MDL_SETTLE_NS  = 1000;
  localparam int unsigned MDL_CLK_MHZ    = 125;
  localparam int unsigned MDL_SETTLE_CYC = (MDL_SETTLE_NS * MDL_CLK_MHZ + 999) / 1000;
  // Per-channel buffer sequence
  typedef enum logic [1:0] {
    MDL_ST_OFF    = 2'b00,
    MDL_ST_FOLLOW = 2'b01,
    MDL_ST_DRIVE  = 2'b10
  } mdl_buf_st_t;
endpackage
`default_nettype wire

// file: hw/mdl_buf_seq.sv
`default_nettype none
module mdl_buf_seq
  import mdl_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = MDL_SETTLE_CYC
) (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic enable_i,
  input  wire logic tristate_i,
  output logic      buf_power_o,
  output logic      buf_src_dac_o,
  output logic      buf_drive_o
);
  ////////////////////////////////////////////////////////////////////////
  localparam int unsigned CW = $clog2(SETTLE_CYC + 1);
  mdl_buf_st_t   state_r;
  mdl_buf_st_t   state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire           go      = enable_i && !tristate_i;
  wire           settled = (cnt_r == CW'(SETTLE_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = '0;
    case (state_r)
      MDL_ST_OFF: begin
        if (go) state_nxt = MDL_ST_FOLLOW;
      end
      MDL_ST_FOLLOW: begin
        cnt_nxt = cnt_r + CW'(1);
        if (!go) state_nxt = MDL_ST_OFF;
        else if (settled) state_nxt = MDL_ST_DRIVE;
      end
      MDL_ST_DRIVE: begin
        if (!go) state_nxt = MDL_ST_OFF;
      end
      default: state_nxt = MDL_ST_OFF;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r <= MDL_ST_OFF;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin is never driven before the buffer has tracked it
  assign buf_power_o   = (state_r != MDL_ST_OFF);
  assign buf_src_dac_o = (state_r == MDL_ST_DRIVE);
  assign buf_drive_o   = (state_r == MDL_ST_DRIVE);
endmodule
`default_nettype wire

// file: verif/mdl_margin_dac_properties.sv
`default_nettype none
module mdl_chk #(
  parameter int unsigned NUM_CH     = 6,
  parameter int unsigned SETTLE_CYC = 4
) (
  input  wire logic                mclk_i,
  input  wire logic                reset_n_i,
  input  wire logic [5:0]          addr_i,
  input  wire logic [15:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  input  wire logic [15:0]         rdata_o,
  input  wire logic                nv_load_i,
  input  wire logic                cfg_done_o,
  input  wire logic [NUM_CH*8-1:0] dac_code_o,
  input  wire logic [NUM_CH*2-1:0] dac_range_o,
  input  wire logic [NUM_CH-1:0]   buf_power_o,
  input  wire logic [NUM_CH-1:0]   buf_src_dac_o,
  input  wire logic [NUM_CH-1:0]   buf_drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Pin is never driven from the follow path, which would glitch the feedback node
  a_drive_src: assert property ((buf_drive_o & ~buf_src_dac_o) == '0) else $error("drive without source");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("stray read data");
  a_cfg_load: assert property (nv_load_i |=> cfg_done_o) else $error("download missed");
  a_no_early: assert property (!cfg_done_o |-> buf_power_o == '0) else $error("power before download");
  a_stat_code: assert property (rd_i && addr_i == 6'h20 |=> rdata_o[7:0] == $past(dac_code_o[7:0]))
    else $error("status code differs");
  a_stat_tri: assert property (rd_i && addr_i == 6'h20 ##1 rdata_o[9] |-> !buf_drive_o[0])
    else $error("driving with bad limits");
  a_drive_delay: assert property ($rose(buf_drive_o[0]) |-> $past(buf_power_o[0], SETTLE_CYC))
    else $error("drive too early");
  a_follow_hold: assert property ($rose(buf_power_o[0]) |-> !buf_src_dac_o[0] [*4])
    else $error("follow too short");
  a_range_wr: assert property (wr_i && addr_i == 6'h18 |=> dac_range_o[1:0] == $past(wdata_i[1:0]))
    else $error("range not applied");
endmodule
bind mdl_margin_dac mdl_chk #(.NUM_CH(NUM_CH), .SETTLE_CYC(SETTLE_CYC)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .nv_load_i(nv_load_i), .cfg_done_o(cfg_done_o), .dac_code_o(dac_code_o),
  .dac_range_o(dac_range_o), .buf_power_o(buf_power_o), .buf_src_dac_o(buf_src_dac_o), .buf_drive_o(buf_drive_o));
`default_nettype wire

// file: verif/mdl_nv_store.sv
`default_nettype none
module mdl_nv_store (
  input  wire logic        mclk_i,
  input  wire logic        go_i,
  output logic             nv_load_o,
  output logic [47:0]      lower_o,
  output logic [47:0]      upper_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Channel n holds lower 0x40+n and upper 0xC0-n
  assign lower_o = 48'h454443424140;
  assign upper_o = 48'hBBBCBDBEBFC0;
  always_ff @(posedge mclk_i) nv_load_o <= go_i;
endmodule
////////////////////////////////////////////////////////////////////////////////
// Converter readback: a higher trim voltage pulls the supply down
module mdl_conv_model (
  input  wire logic [7:0]  dac_i,
  output logic      [7:0]  vout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign vout_o = 8'hFF - dac_i;
endmodule
`default_nettype wire

// file: verif/tb_margin_dac_limit_control.sv
`default_nettype none
module tb_margin_dac_limit_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, nv_go = 1'b0, nv_load;
  logic [5:0]  addr_i = 6'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic [47:0] nv_lo, nv_hi, dac_code_o;
  logic [11:0] dac_range_o;
  logic [5:0]  pwr, src, drv;
  logic        cfg_done_o;
  logic [7:0]  supply;
  int          err_count = 0, checks = 0;
  mdl_nv_store u_nv (.mclk_i(mclk_i), .go_i(nv_go), .nv_load_o(nv_load), .lower_o(nv_lo), .upper_o(nv_hi));
  mdl_margin_dac #(.SETTLE_CYC(4)) DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nv_load_i(nv_load), .nv_lower_i(nv_lo), .nv_upper_i(nv_hi),
    .cfg_done_o(cfg_done_o), .dac_code_o(dac_code_o), .dac_range_o(dac_range_o), .buf_power_o(pwr),
    .buf_src_dac_o(src), .buf_drive_o(drv));
  mdl_conv_model u_conv (.dac_i(dac_code_o[15:8]), .vout_o(supply));
  initial forever #4 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task rd(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o & m, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Enable before download must not power anything: limits reset crossed
  task t_reset;
    rd(6'h00, 16'hFFFF, 16'h007F);
    rd(6'h08, 16'hFFFF, 16'h00FF);
    rd(6'h10, 16'hFFFF, 16'h0000);
    rd(6'h20, 16'h0300, 16'h0200);
    wr(6'h18, 16'h0004);
    repeat (8) @(negedge mclk_i);
    chk({10'h000, pwr}, 16'h0000);
    wr(6'h18, 16'h0000);
    @(posedge mclk_i);
    nv_go <= 1'b1;
    @(posedge mclk_i);
    nv_go <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk({15'h0000, cfg_done_o}, 16'h0001);
    rd(6'h0D, 16'hFFFF, 16'h0045);
    rd(6'h15, 16'hFFFF, 16'h00BB);
  endtask
  task t_clamp;
    logic [7:0] c, lo, hi, e;
    for (int n = 0; n < 6; n++) begin
      for (int k = 0; k < 5; k++) begin
        lo = 8'h40 + 8'(n);
        hi = 8'hC0 - 8'(n);
        c = (k == 0) ? 8'h00 : (k == 1) ? lo : (k == 2) ? hi : (k == 3) ? hi + 8'h01 : 8'h7F;
        e = (c < lo) ? lo : (c > hi) ? hi : c;
        wr(6'(n), {8'h00, c});
        chk({8'h00, dac_code_o[8*n+:8]}, {8'h00, e});
        rd(6'h20 + 6'(n), 16'h00FF, {8'h00, e});
      end
    end
  endtask
  // Ranges, then the follow-then-drive turn-on and the crossed-limit shutdown
  task t_seq;
    int w;
    for (int r = 0; r < 4; r++) begin
      wr(6'h18, 16'(r));
      chk({14'h0000, dac_range_o[1:0]}, 16'(r));
    end
    wr(6'h00, 16'h007F);
    wr(6'h18, 16'h0007);
    for (w = 0; w < 20 && pwr[0] !== 1'b1; w++) @(negedge mclk_i);
    chk({14'h0000, src[0], drv[0]}, 16'h0000);
    for (w = 0; w < 20 && drv[0] !== 1'b1; w++) @(negedge mclk_i);
    chk(16'(w), 16'h0004);
    chk({15'h0000, src[0]}, 16'h0001);
    wr(6'h08, 16'h00D0);
    chk({15'h0000, drv[0]}, 16'h0000);
    @(negedge mclk_i);
    chk({15'h0000, pwr[0]}, 16'h0000);
    rd(6'h20, 16'h0300, 16'h0200);
    rd(6'h3F, 16'hFFFF, 16'h0000);
  endtask
  // Host trims channel 1 until the converter readback hits its target
  task t_loop;
    logic [7:0] code;
    int         it;
    wr(6'h19, 16'h0000);
    code = 8'h7F;
    wr(6'h01, {8'h00, code});
    wr(6'h19, 16'h0004);
    for (it = 0; it < 40 && supply != 8'h60; it++) begin
      code = (supply > 8'h60) ? code + 8'h01 : code - 8'h01;
      wr(6'h01, {8'h00, code});
    end
    chk({8'h00, supply}, 16'h0060);
    rd(6'h21, 16'h00FF, 16'h009F);
    for (it = 0; it < 20 && drv[1] !== 1'b1; it++) @(negedge mclk_i);
    chk({14'h0000, src[1], drv[1]}, 16'h0003);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_clamp();
    t_seq();
    t_loop();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
